// ===== tbac_core.sv
`timescale 1ns/100ps
`include "tbac_params.svh"
module tbac_core
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic rx_sof,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic rx_eof,
  input wire logic [2:0] cmd_code,
  input wire logic [3:0] cmd_n,
  input wire logic [3:0] cmd_slot,
  input wire logic cmd_afi_match,
  input wire logic cmd_pupi_match,
  input wire logic cmd_cid_match,
  input wire logic tx_start,
  input wire logic tx_bit_valid,
  input wire logic tx_bit,
  input wire logic tx_crc_go,
  output logic frame_ok,
  output logic frame_bad,
  output logic atqb_req,
  output logic attrib_ok,
  output logic deselect_ok,
  output logic [1:0] tag_state,
  output logic [3:0] slot_value,
  output logic tx_crc_bit,
  output logic tx_crc_busy
);
  tbac_pkg::tbac_state_e state_reg;
  logic [15:0] lfsr_reg;
  logic [3:0] n_reg;
  logic [15:0] rx_crc;
  logic rx_ok;
  logic [15:0] tx_crc;
  logic tx_sh_bit;
  logic [4:0] tx_cnt_reg;
  logic rx_open_reg;
  logic cmd_ok;
  logic enroll;
  logic [3:0] draw;
  logic [7:0] prod;

  tbac_crc u_rx_crc
  (
    .clk(clk),
    .arst_n(arst_n),
    .start(rx_sof),
    .bit_valid(rx_bit_valid),
    .bit_in(rx_bit),
    .load(1'b0),
    .shift(1'b0),
    .crc_reg(rx_crc),
    .tx_bit(),
    .ok(rx_ok)
  );

  tbac_crc u_tx_crc
  (
    .clk(clk),
    .arst_n(arst_n),
    .start(tx_start),
    .bit_valid(tx_bit_valid),
    .bit_in(tx_bit),
    .load(tx_crc_go),
    .shift(tx_cnt_reg != 5'h00),
    .crc_reg(tx_crc),
    .tx_bit(tx_sh_bit),
    .ok()
  );

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rx_open_reg <= 1'b0;
    else if (rx_sof)
      rx_open_reg <= 1'b1;
    else if (rx_eof)
      rx_open_reg <= 1'b0;
  end

  // command acts only at end of a frame whose check passed
  assign cmd_ok = rx_eof && rx_open_reg && rx_ok;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      frame_ok <= 1'b0;
      frame_bad <= 1'b0;
    end
    else
    begin
      frame_ok <= cmd_ok;
      frame_bad <= rx_eof && rx_open_reg && !rx_ok;
    end
  end

  // runs every cycle from reset, so draw time depends on reader timing
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      lfsr_reg <= `TBAC_LFSR_SEED;
    else if (lfsr_reg[0])
      lfsr_reg <= (lfsr_reg >> 1) ^ `TBAC_LFSR_TAPS;
    else
      lfsr_reg <= lfsr_reg >> 1;
  end

  // scale random nibble into 1..N by multiply-high; no division needed
  always_comb
  begin
    // a random nibble times N keeps the high nibble inside 0..N-1
    prod = {4'h0, lfsr_reg[3:0]} * {4'h0, n_eff(cmd_n)};
    draw = prod[7:4] + 4'h1;
  end

  function automatic logic [3:0] n_eff(input logic [3:0] n);
    n_eff = (n == 4'h0) ? 4'h1 : n;
  endfunction : n_eff

  always_comb
  begin
    enroll = 1'b0;
    case (state_reg)
      tbac_pkg::TBAC_IDLE, tbac_pkg::TBAC_READY:
        enroll = (cmd_code == `TBAC_CMD_REQ) ||
                 (cmd_code == `TBAC_CMD_WUP && cmd_afi_match);
      tbac_pkg::TBAC_HALT:
        enroll = (cmd_code == `TBAC_CMD_WUP) && cmd_afi_match;
      default:
        enroll = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= tbac_pkg::TBAC_IDLE;
    else if (cmd_ok)
    begin
      case (state_reg)
        tbac_pkg::TBAC_IDLE, tbac_pkg::TBAC_HALT:
          if (enroll)
            state_reg <= tbac_pkg::TBAC_READY;
        tbac_pkg::TBAC_READY:
          if (cmd_code == `TBAC_CMD_HALT && cmd_pupi_match)
            state_reg <= tbac_pkg::TBAC_HALT;
          else if (cmd_code == `TBAC_CMD_ATTR && cmd_pupi_match)
            state_reg <= tbac_pkg::TBAC_ACTIVE;
        tbac_pkg::TBAC_ACTIVE:
          if (cmd_code == `TBAC_CMD_DESEL && cmd_cid_match)
            state_reg <= tbac_pkg::TBAC_HALT;
        default:
          state_reg <= tbac_pkg::TBAC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      slot_value <= 4'h0;
      n_reg <= 4'h1;
    end
    else if (cmd_ok && enroll)
    begin
      n_reg <= n_eff(cmd_n);
      slot_value <= (n_eff(cmd_n) == 4'h1) ? 4'h1 : draw;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      atqb_req <= 1'b0;
    else if (cmd_ok && enroll)
      atqb_req <= (n_eff(cmd_n) == 4'h1) || (draw == 4'h1);
    else if (cmd_ok && state_reg == tbac_pkg::TBAC_READY && cmd_code == `TBAC_CMD_SLOT)
      atqb_req <= (cmd_slot == slot_value) && (slot_value != 4'h1);
    else
      atqb_req <= 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      attrib_ok <= 1'b0;
      deselect_ok <= 1'b0;
    end
    else
    begin
      attrib_ok <= cmd_ok && state_reg == tbac_pkg::TBAC_READY &&
                   cmd_code == `TBAC_CMD_ATTR && cmd_pupi_match;
      deselect_ok <= cmd_ok && state_reg == tbac_pkg::TBAC_ACTIVE &&
                     cmd_code == `TBAC_CMD_DESEL && cmd_cid_match;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tag_state <= 2'h0;
    else
      tag_state <= state_reg;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tx_cnt_reg <= 5'h00;
    else if (tx_crc_go)
      tx_cnt_reg <= `TBAC_CRC_BITS;
    else if (tx_cnt_reg != 5'h00)
      tx_cnt_reg <= tx_cnt_reg - 5'h01;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_crc_bit <= 1'b0;
      tx_crc_busy <= 1'b0;
    end
    else
    begin
      tx_crc_bit <= tx_sh_bit;
      tx_crc_busy <= tx_cnt_reg != 5'h00;
    end
  end
endmodule : tbac_core

// ===== tbac_params.svh
`ifndef TBAC_PARAMS_SVH
`define TBAC_PARAMS_SVH
// command codes on the decoded-command port
`define TBAC_CMD_REQ 3'h0
`define TBAC_CMD_WUP 3'h1
`define TBAC_CMD_SLOT 3'h2
`define TBAC_CMD_ATTR 3'h3
`define TBAC_CMD_HALT 3'h4
`define TBAC_CMD_DESEL 3'h5
// check-value generator
`define TBAC_CRC_PRESET 16'hFFFF
`define TBAC_CRC_POLY_REFL 16'h8408
`define TBAC_CRC_BITS 5'h10
// register value after data plus its own inverted check, reflected form
`define TBAC_CRC_RESIDUE 16'hF0B8
// random source
`define TBAC_LFSR_SEED 16'hACE1
`define TBAC_LFSR_TAPS 16'hB400
`endif

// ===== tbac_pkg.sv
package tbac_pkg;
  typedef enum logic [1:0] {TBAC_IDLE, TBAC_READY, TBAC_HALT, TBAC_ACTIVE} tbac_state_e;
  typedef logic [15:0] tbac_crc_t;
endpackage : tbac_pkg

// ===== tbac_crc.sv
`timescale 1ns/100ps
`include "tbac_params.svh"
module tbac_crc
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic bit_valid,
  input wire logic bit_in,
  input wire logic load,
  input wire logic shift,
  output tbac_pkg::tbac_crc_t crc_reg,
  output logic tx_bit,
  output logic ok
);
  tbac_pkg::tbac_crc_t crc_next;
  tbac_pkg::tbac_crc_t sh_reg;

  // reflected form: lsb-first bit stream, same polynomial
  always_comb
  begin
    crc_next = crc_reg >> 1;
    if (crc_reg[0] ^ bit_in)
    begin
      crc_next = crc_next ^ `TBAC_CRC_POLY_REFL;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      crc_reg <= `TBAC_CRC_PRESET;
    else if (start)
      crc_reg <= `TBAC_CRC_PRESET;
    else if (bit_valid)
      crc_reg <= crc_next;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sh_reg <= 16'h0000;
    else if (load)
      sh_reg <= ~crc_reg;
    else if (shift)
      sh_reg <= sh_reg >> 1;
  end

  assign tx_bit = sh_reg[0];
  // running over data plus received inverted check gives the fixed residue
  assign ok = (crc_reg == `TBAC_CRC_RESIDUE);
endmodule : tbac_crc

// ===== tbac_core_assertions.sv
`timescale 1ns/100ps
`include "tbac_params.svh"
module tbac_chk
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic rx_eof,
  input wire logic [2:0] cmd_code,
  input wire logic [3:0] cmd_n,
  input wire logic frame_ok,
  input wire logic frame_bad,
  input wire logic atqb_req,
  input wire logic [1:0] tag_state,
  input wire logic [3:0] slot_value,
  input wire logic tx_crc_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic req = rx_eof && cmd_code == `TBAC_CMD_REQ;
  wire logic free = tag_state < 2'h2;
  a_flag_after_eof: assert property ((frame_ok || frame_bad) |-> $past(rx_eof))
    else $error("frame flag without end of frame");
  a_bad_silent: assert property (frame_bad |-> !frame_ok && !atqb_req)
    else $error("failed frame answered");
  a_answer_good: assert property (atqb_req |-> frame_ok)
    else $error("answer without good frame");
  a_active_quiet: assert property (rx_eof && tag_state == 2'h3 |=> !atqb_req)
    else $error("active tag answered");
  a_halt_deaf: assert property (req && tag_state == 2'h2 |=> !atqb_req)
    else $error("halted tag answered request");
  a_one_slot: assert property (req && cmd_n == 4'h1 && free ##1 frame_ok |-> atqb_req)
    else $error("no answer for single slot");
  a_slot_range: assert property (req && cmd_n > 4'h1 && free ##1 frame_ok |=>
    slot_value > 4'h0 && slot_value <= $past(cmd_n, 2))
    else $error("slot value out of range");
  a_busy_len: assert property ($rose(tx_crc_busy) |->
    tx_crc_busy [*8] ##1 tx_crc_busy [*8] ##1 !tx_crc_busy)
    else $error("check shift length wrong");
endmodule : tbac_chk
bind tbac_core tbac_chk u_chk (.*);

// ===== tbac_rdr.sv
`timescale 1ns/100ps
`include "tbac_params.svh"
module tbac_rdr
(
  input wire logic clk,
  input wire logic frame_ok,
  input wire logic frame_bad,
  input wire logic atqb_req,
  output logic rx_sof,
  output logic rx_bit_valid,
  output logic rx_bit,
  output logic rx_eof,
  output logic [2:0] cmd_code,
  output logic [3:0] cmd_n,
  output logic [3:0] cmd_slot,
  output logic [2:0] cmd_m
);
  logic ok, bad, atqb;
  initial {rx_sof, rx_bit_valid, rx_bit, rx_eof, cmd_code, cmd_n, cmd_slot, cmd_m} = '0;
  function automatic tbac_pkg::tbac_crc_t upd(tbac_pkg::tbac_crc_t c, logic b);
    upd = (c >> 1) ^ ((c[0] ^ b) ? `TBAC_CRC_POLY_REFL : 16'h0000);
  endfunction : upd
  // err flips one check bit so the frame must be refused
  task automatic frame(input logic [2:0] c, input logic [3:0] n, s, input logic [2:0] m,
    input logic err);
    tbac_pkg::tbac_crc_t crc;
    logic [23:0] d;
    crc = `TBAC_CRC_PRESET;
    for (int i = 0; i < 8; i++)
      crc = upd(crc, i < 3 ? c[i] : i[0]);
    d = {~crc ^ {15'h0000, err}, 5'h15, c};
    @(posedge clk) rx_sof <= 1'b1;
    for (int i = 0; i < 24; i++)
    begin
      @(posedge clk) {rx_sof, rx_bit_valid, rx_bit} <= {2'b01, d[i]};
    end
    // data line shows the inverse of its last bit once released
    @(posedge clk) {rx_bit_valid, rx_bit, rx_eof, cmd_code, cmd_n, cmd_slot, cmd_m} <=
      {1'b0, ~d[23], 1'b1, c, n, s, m};
    @(posedge clk) rx_eof <= 1'b0;
    #1 {ok, bad, atqb} = {frame_ok, frame_bad, atqb_req};
    // tag_state trails the internal state by one cycle
    repeat (2) @(posedge clk);
  endtask : frame
endmodule : tbac_rdr

// ===== tb_top.sv
`timescale 1ns/100ps
`include "tbac_params.svh"
module tb_top;
  logic clk, arst_n, tx_start, tx_bit_valid, tx_bit, tx_crc_go, r_at, r_de;
  logic rx_sof, rx_bit_valid, rx_bit, rx_eof, frame_ok, frame_bad, atqb_req;
  logic attrib_ok, deselect_ok, tx_crc_bit, tx_crc_busy;
  logic [2:0] cmd_code, cmd_m;
  logic [3:0] cmd_n, cmd_slot, slot_value, r;
  logic [1:0] tag_state;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  tbac_core dut (.*, .cmd_afi_match(cmd_m[2]), .cmd_pupi_match(cmd_m[1]),
    .cmd_cid_match(cmd_m[0]));
  tbac_rdr rdr (.*);
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // sticky capture: these one-cycle pulses are not sampled by the frame task
  always @(posedge clk)
    {r_at, r_de} <= arst_n ? {r_at | attrib_ok, r_de | deselect_ok} : 2'b00;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic t_crc;
    tbac_pkg::tbac_crc_t e;
    e = `TBAC_CRC_PRESET;
    @(posedge clk) tx_start <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      e = rdr.upd(e, i[0] ^ i[2]);
      @(posedge clk) {tx_start, tx_bit_valid, tx_bit} <= {2'b01, i[0] ^ i[2]};
    end
    @(posedge clk) {tx_bit_valid, tx_crc_go} <= 2'b01;
    @(posedge clk) tx_crc_go <= 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk) #1 chk({tx_crc_bit, tx_crc_busy}, {!e[i], 1'b1});
    end
    @(posedge clk) #1 chk(tx_crc_busy, 1'b0);
  endtask : t_crc
  task automatic t_req;
    rdr.frame(`TBAC_CMD_REQ, 4'h1, 4'h0, 3'h7, 1'b1);
    chk({rdr.ok, rdr.bad, rdr.atqb, tag_state}, 5'h08);
    rdr.frame(`TBAC_CMD_REQ, 4'h1, 4'h0, 3'h7, 1'b0);
    chk({rdr.ok, rdr.bad, rdr.atqb, tag_state}, 5'h15);
  endtask : t_req
  task automatic t_slot;
    repeat (2)
    begin
      rdr.frame(`TBAC_CMD_REQ, 4'h8, 4'h0, 3'h7, 1'b0);
      r = slot_value;
      chk(r >= 4'h1 && r <= 4'h8, 1'b1);
      chk(rdr.atqb, r == 4'h1);
      for (int s = 8; s > 1; s--)
      begin
        rdr.frame(`TBAC_CMD_SLOT, 4'h8, s[3:0], 3'h7, 1'b0);
        chk(rdr.atqb, r == s[3:0]);
      end
    end
  endtask : t_slot
  task automatic t_halt;
    rdr.frame(`TBAC_CMD_HALT, 4'h1, 4'h0, 3'h2, 1'b0);
    rdr.frame(`TBAC_CMD_REQ, 4'h1, 4'h0, 3'h7, 1'b0);
    chk({rdr.atqb, tag_state}, 3'h2);
    rdr.frame(`TBAC_CMD_WUP, 4'h1, 4'h0, 3'h3, 1'b0);
    chk(rdr.atqb, 1'b0);
    rdr.frame(`TBAC_CMD_WUP, 4'h1, 4'h0, 3'h4, 1'b0);
    chk(rdr.atqb, 1'b1);
  endtask : t_halt
  task automatic t_act;
    rdr.frame(`TBAC_CMD_ATTR, 4'h1, 4'h0, 3'h2, 1'b0);
    chk({r_at, tag_state}, 3'h7);
    rdr.frame(`TBAC_CMD_WUP, 4'h1, 4'h0, 3'h7, 1'b0);
    chk({rdr.atqb, tag_state}, 3'h3);
    rdr.frame(`TBAC_CMD_DESEL, 4'h1, 4'h0, 3'h6, 1'b0);
    chk({rdr.atqb, r_de}, 2'h0);
    rdr.frame(`TBAC_CMD_DESEL, 4'h1, 4'h0, 3'h7, 1'b0);
    chk({r_de, tag_state}, 3'h6);
  endtask : t_act
  initial
  begin
    {arst_n, tx_start, tx_bit_valid, tx_bit, tx_crc_go} = '0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_crc();
    t_req();
    t_slot();
    t_halt();
    t_act();
    summarize();
  end
endmodule : tb_top
